// >>> rtl/compact_timer_pkg.sv
package compact_timer_pkg;

   // register byte addresses on the AXI4-Lite slave
   localparam logic [4:0] ADDR_CONTROL_PRIMARY   = 5'h00;
   localparam logic [4:0] ADDR_CONTROL_SECONDARY = 5'h04;
   localparam logic [4:0] ADDR_COUNTER_LOW       = 5'h08;
   localparam logic [4:0] ADDR_COUNTER_HIGH      = 5'h0C;
   localparam logic [4:0] ADDR_COMPARE_A_LOW     = 5'h10;
   localparam logic [4:0] ADDR_COMPARE_A_HIGH    = 5'h14;
   localparam logic [4:0] ADDR_PIN_SELECT        = 5'h18;

   // field positions in the primary control register
   localparam int POS_PAUSE    = 7;
   localparam int POS_CLK_HI   = 6;
   localparam int POS_CLK_LO   = 4;
   localparam int POS_ON       = 3;
   localparam int POS_PERIOD_HI = 2;

   // field positions in the secondary control register
   localparam int POS_MODE_HI  = 7;
   localparam int POS_MODE_LO  = 6;
   localparam int POS_ACT_HI   = 5;
   localparam int POS_ACT_LO   = 4;
   localparam int POS_INIT     = 3;
   localparam int POS_POL      = 2;
   localparam int POS_SWAP     = 1;
   localparam int POS_CLRSEL   = 0;

   // pin select bits
   localparam int POS_PIN_IN   = 0;
   localparam int POS_PIN_OUT  = 1;

   // reset values
   localparam logic [7:0] RESET_CONTROL = 8'h00;
   localparam logic [9:0] RESET_COUNT   = 10'h000;

   // prescale counts for the internal clock choices
   localparam int DIV_SYS4  = 4;
   localparam int DIV_HI16  = 16;
   localparam int DIV_HI64  = 64;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // counter clock choices
   typedef enum logic [2:0] {
      CLK_SYS_DIV4 = 3'b000,
      CLK_SYS      = 3'b001,
      CLK_HI_DIV16 = 3'b010,
      CLK_HI_DIV64 = 3'b011,
      CLK_SUB_A    = 3'b100,
      CLK_SUB_B    = 3'b101,
      CLK_EXT_RISE = 3'b110,
      CLK_EXT_FALL = 3'b111
   } count_clock_select_t;

   // operating modes
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF   = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } operating_mode_select_t;

   // interrupt request pulses toward the interrupt controller
   typedef struct packed {
      logic matchA;
      logic matchP;
   } match_irq_t;

endpackage : compact_timer_pkg

// >>> rtl/compact_timer_module.sv
`timescale 1ns/10ps

module compact_timer_module
   import compact_timer_pkg::*;
#(
   parameter int COUNT_WIDTH = 10
) (
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // sub clock and high internal clock, sampled and counted on their rising edges
   input  wire logic                high_internal_clock,
   input  wire logic                sub_clock,
   input  wire logic                timer_clock_pin,
   // axi4-lite slave
   input  wire logic [4:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [4:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // timer output and pin-share control
   output logic                     timer_output_pin,
   output logic                     timerOutputSelected,
   output logic                     timerInputSelected,
   output match_irq_t               matchIrq
);

   logic [7:0]             controlPrimary;   // pause, clock, on, period
   logic [7:0]             controlSecondary; // mode, action, init, ...
   logic [1:0]             pinSelect;        // pin-share bits
   logic [COUNT_WIDTH-1:0] count;            // the timer core
   logic [9:0]             compareA;         // comparator A value
   logic [7:0]             holdBuffer;       // shared low-byte buffer
   logic                   onPrev;           // for on-bit edge detect
   logic [5:0]             prescale;         // sys clock divider
   logic                   hiPrev;           // high clock edge detect
   logic                   subPrev;          // sub clock edge detect
   logic [5:0]             hiDiv;            // high clock divider
   logic                   pinSync1;         // first sync stage only
   logic                   pinSync2;
   logic                   pinSync3;         // history for edge detect
   logic                   tick;             // one count this cycle
   logic                   matchA;
   logic                   matchP;
   logic                   overflow;
   logic                   clearCount;
   logic                   onRise;
   logic                   running;

   // decoded views of the control fields
   count_clock_select_t    clockSel;
   operating_mode_select_t mode;
   logic [2:0]             periodBits;

   assign clockSel   = count_clock_select_t'(
      controlPrimary[POS_CLK_HI:POS_CLK_LO]);
   assign periodBits = controlPrimary[POS_PERIOD_HI:0];
   assign mode       = operating_mode_select_t'(
      controlSecondary[POS_MODE_HI:POS_MODE_LO]);
   assign onRise     = controlPrimary[POS_ON] & ~onPrev;
   // pause and off both freeze the count, only turning on again clears it
   assign running    = controlPrimary[POS_ON]
                       & ~controlPrimary[POS_PAUSE];

   // external pin synchroniser; stage one feeds stage two only
   // the pin is gated first, so an unrouted pin never counts
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinSync1 <= 1'b0;
         pinSync2 <= 1'b0;
         pinSync3 <= 1'b0;
      end else begin
         pinSync1 <= timer_clock_pin & pinSelect[POS_PIN_IN];
         pinSync2 <= pinSync1;
         pinSync3 <= pinSync2;
      end
   end

   // prescalers; high clock divided by counting its rising edges
   // prescale runs free, so the first /4 tick may come early
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale <= 6'h00;
         hiPrev   <= 1'b0;
         subPrev  <= 1'b0;
         hiDiv    <= 6'h00;
      end else begin
         prescale <= prescale + 6'h01;
         hiPrev   <= high_internal_clock;
         subPrev  <= sub_clock;
         if (high_internal_clock & ~hiPrev) begin
            hiDiv <= hiDiv + 6'h01;
         end
      end
   end

   // one-cycle count enable from the selected source
   // the divided clocks count edges of their inputs, not levels
   always_comb begin
      logic hiEdge;
      hiEdge = high_internal_clock & ~hiPrev;
      case (clockSel)
         CLK_SYS_DIV4: tick = (prescale[1:0] == 2'(DIV_SYS4 - 1));
         CLK_SYS:      tick = 1'b1;
         CLK_HI_DIV16: tick = hiEdge & (hiDiv[3:0] == 4'(DIV_HI16 - 1));
         CLK_HI_DIV64: tick = hiEdge & (hiDiv == 6'(DIV_HI64 - 1));
         CLK_SUB_A,
         CLK_SUB_B:    tick = sub_clock & ~subPrev;
         CLK_EXT_RISE: tick = pinSync2 & ~pinSync3;
         CLK_EXT_FALL: tick = ~pinSync2 & pinSync3;
         default:      tick = 1'b0;
      endcase
   end

   // comparators act on the counter value being left behind
   assign matchA   = tick & running & (count == compareA);
   // P fires on the last count below P*128, giving a period of P*128
   // ticks; zero leaves the period to the overflow at full count
   assign matchP   = tick & running & (periodBits != 3'h0)
                     & (count[COUNT_WIDTH-1 -: 3] == (periodBits - 3'h1))
                     & (count[COUNT_WIDTH-4:0] == '1);
   // overflow is the tick that would wrap the counter past its top
   assign overflow = tick & running & (count == '1);
   // pwm mode clears on the period comparator chosen by the swap bit
   always_comb begin
      if (mode == MODE_PWM) begin
         clearCount = controlSecondary[POS_SWAP] ? matchA
                      : (matchP | (periodBits == 3'h0 && overflow));
      end else if (controlSecondary[POS_CLRSEL]) begin
         clearCount = matchA;
      end else begin
         clearCount = matchP | (periodBits == 3'h0 && overflow);
      end
   end

   // the counter itself
   // the on-bit edge wins over any clear or count in the same cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count  <= RESET_COUNT;
         onPrev <= 1'b0;
      end else begin
         onPrev <= controlPrimary[POS_ON];
         if (onRise) begin
            count <= RESET_COUNT;
         end else if (clearCount) begin
            count <= RESET_COUNT;
         end else if (tick & running) begin
            count <= count + 1'b1;
         end
      end
   end

   // interrupt pulses, one cycle per match
   // each pulse rises on the edge that clears or counts past the match, one cycle after it
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         matchIrq <= '0;
      end else begin
         matchIrq.matchA <= matchA;
         matchIrq.matchP <= matchP | (periodBits == 3'h0 && overflow);
      end
   end

   // output waveform; level before polarity inversion
   // timer/counter mode leaves the level alone
   logic outLevel;
   logic pwmActive;
   logic [9:0] dutyValue;
   assign dutyValue = controlSecondary[POS_SWAP]
                      ? {periodBits, 7'h00} : compareA;
   assign pwmActive = (count < dutyValue);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         outLevel <= 1'b0;
      end else if (onRise) begin
         outLevel <= controlSecondary[POS_INIT];
      end else if (mode == MODE_COMPARE && matchA) begin
         case (controlSecondary[POS_ACT_HI:POS_ACT_LO])
            2'b01:   outLevel <= 1'b0;
            2'b10:   outLevel <= 1'b1;
            2'b11:   outLevel <= ~outLevel;
            default: outLevel <= outLevel;
         endcase
      end else if (mode == MODE_PWM) begin
         case (controlSecondary[POS_ACT_HI:POS_ACT_LO])
            2'b00:   outLevel <= ~controlSecondary[POS_INIT];
            2'b01:   outLevel <= controlSecondary[POS_INIT];
            // init set means active high, clear means active low
            2'b10:   outLevel <= pwmActive ~^ controlSecondary[POS_INIT];
            // action 11 is undefined here and simply holds the level
            default: outLevel <= outLevel;
         endcase
      end
   end

   // pin drive with polarity; low when the pin keeps its other job
   // registered so the pin never glitches through the polarity xor
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_output_pin    <= 1'b0;
         timerOutputSelected <= 1'b0;
         timerInputSelected  <= 1'b0;
      end else begin
         timer_output_pin    <= pinSelect[POS_PIN_OUT] &
                                (outLevel ^ controlSecondary[POS_POL]);
         timerOutputSelected <= pinSelect[POS_PIN_OUT];
         timerInputSelected  <= pinSelect[POS_PIN_IN];
      end
   end

   // axi write path: address and data taken in either order
   logic       awHeld;
   logic       wHeld;
   logic [4:0] awAddr;
   logic [7:0] wByte;
   logic       wLane0;
   logic       doWrite;
   // the write waits while the previous response is still unread
   assign doWrite = awHeld & wHeld & ~s_axi_bvalid;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld        <= 1'b0;
         wHeld         <= 1'b0;
         awAddr        <= 5'h00;
         wByte         <= 8'h00;
         wLane0        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         // each ready pulses once, and only while its own channel has nothing parked
         s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready  <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld  <= 1'b1;
            wByte  <= s_axi_wdata[7:0];
            wLane0 <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // the counter pair is read-only, so writes to it are refused
            if (awAddr == ADDR_COUNTER_LOW || awAddr == ADDR_COUNTER_HIGH
                || awAddr > ADDR_PIN_SELECT || awAddr[1:0] != 2'h0) begin
               s_axi_bresp <= RESP_SLVERR;
            end else begin
               s_axi_bresp <= RESP_OKAY;
            end
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi read path
   logic readTake;
   assign readTake = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         // one read at a time: arready stays low while rvalid stands
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (readTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == ADDR_CONTROL_PRIMARY) begin
               s_axi_rdata <= {24'h000000, controlPrimary};
            end else if (s_axi_araddr == ADDR_CONTROL_SECONDARY) begin
               s_axi_rdata <= {24'h000000, controlSecondary};
            end else if (s_axi_araddr == ADDR_COUNTER_LOW ||
                         s_axi_araddr == ADDR_COMPARE_A_LOW) begin
               s_axi_rdata <= {24'h000000, holdBuffer};
            end else if (s_axi_araddr == ADDR_COUNTER_HIGH) begin
               s_axi_rdata <= {30'h0, count[9:8]};
            end else if (s_axi_araddr == ADDR_COMPARE_A_HIGH) begin
               s_axi_rdata <= {30'h0, compareA[9:8]};
            end else if (s_axi_araddr == ADDR_PIN_SELECT) begin
               s_axi_rdata <= {30'h0, pinSelect};
            end else begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // registers; software access order is the caller's duty
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         controlPrimary   <= RESET_CONTROL;
         controlSecondary <= RESET_CONTROL;
         pinSelect        <= 2'h0;
         compareA         <= 10'h000;
         holdBuffer       <= 8'h00;
      end else begin
         // high-byte reads latch the live low byte
         if (readTake && s_axi_araddr == ADDR_COUNTER_HIGH) begin
            holdBuffer <= count[7:0];
         end else if (readTake && s_axi_araddr == ADDR_COMPARE_A_HIGH) begin
            holdBuffer <= compareA[7:0];
         end
         // a write with lane 0 off changes nothing; a low write in the
         // same cycle as a high read wins, as the later assignment
         if (doWrite && wLane0) begin
            if (awAddr == ADDR_CONTROL_PRIMARY) begin
               controlPrimary <= wByte;
            end else if (awAddr == ADDR_CONTROL_SECONDARY) begin
               controlSecondary <= wByte;
            end else if (awAddr == ADDR_COMPARE_A_LOW) begin
               holdBuffer <= wByte;
            end else if (awAddr == ADDR_COMPARE_A_HIGH) begin
               compareA <= {wByte[1:0], holdBuffer};
            end else if (awAddr == ADDR_PIN_SELECT) begin
               pinSelect <= wByte[1:0];
            end
         end
      end
   end

endmodule : compact_timer_module

// >>> test/compact_timer_module_properties.sv
`timescale 1ns/10ps
module compact_timer_module_properties
   import compact_timer_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [4:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        timer_output_pin,
   input wire logic        timerOutputSelected,
   input wire match_irq_t  matchIrq
);
   localparam logic [4:0] ADDR_GAP = 5'h1C;  // first unmapped word
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("rvalid dropped early");
   property p_rlat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_awone;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   a_awone: assert property (p_awone) else $error("awready held too long");
   // pin and select flag are registered together in the same stage
   property p_pinoff;
      !timerOutputSelected && !$past(timerOutputSelected) |-> !timer_output_pin;
   endproperty
   a_pinoff: assert property (p_pinoff) else $error("pin driven unrouted");
   property p_cntwr;
      s_axi_awvalid && s_axi_awready && (s_axi_awaddr == ADDR_COUNTER_LOW ||
         s_axi_awaddr == ADDR_COUNTER_HIGH) |-> ##[1:4]
         (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   endproperty
   a_cntwr: assert property (p_cntwr) else $error("counter write taken");
   property p_gap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_GAP |=>
         s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_gap: assert property (p_gap) else $error("unmapped read accepted");
   property p_hiread;
      s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_COUNTER_HIGH ||
         s_axi_araddr == ADDR_COMPARE_A_HIGH) |=>
         s_axi_rdata[31:2] == 30'h0 && s_axi_rresp == RESP_OKAY;
   endproperty
   a_hiread: assert property (p_hiread) else $error("high byte too wide");
   c_matchA: cover property (matchIrq.matchA);
   c_matchP: cover property (matchIrq.matchP);
   c_pinRise: cover property ($rose(timer_output_pin));
endmodule : compact_timer_module_properties

bind compact_timer_module compact_timer_module_properties chk (
   .sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_rdata, .s_axi_rresp, .timer_output_pin, .timerOutputSelected,
   .matchIrq
);

// >>> test/timer_far_side.sv
`timescale 1ns/10ps
module timer_far_side (
   input  wire logic sys_clk,
   output logic      high_internal_clock,
   output logic      sub_clock,
   output logic      timer_clock_pin
);
   logic [3:0] subDiv;  // sub clock divider, one rise per 16 cycles
   initial begin
      high_internal_clock = 1'b0;
      sub_clock = 1'b0;
      timer_clock_pin = 1'b0;
      subDiv = 4'h0;
   end
   // internal clocks run free; the event pin only moves on request
   always @(posedge sys_clk) begin
      high_internal_clock <= ~high_internal_clock;
      subDiv <= subDiv + 4'h1;
      sub_clock <= subDiv[3];
   end
   // events wide enough for a two-flop synchroniser
   task automatic pulses(input int n);
      repeat (n) begin
         level(1'b1);
         level(1'b0);
      end
   endtask : pulses
   task automatic level(input logic v);
      @(posedge sys_clk);
      timer_clock_pin <= v;
      repeat (7) @(posedge sys_clk);
   endtask : level
endmodule : timer_far_side

// >>> test/compact_timer_module_bench.sv
`timescale 1ns/10ps
module compact_timer_module_bench;
   import compact_timer_pkg::*;
   logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, resp;
   logic [3:0]  wstrb;
   logic        hiClk, subClk, extPin, pin, outSel, inSel, pinQ;
   logic [9:0]  cnt;
   match_irq_t  irq;
   int          miscompares, n_compared, guard, aCount, n;
   compact_timer_module dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .high_internal_clock(hiClk), .sub_clock(subClk),
      .timer_clock_pin(extPin), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_output_pin(pin),
      .timerOutputSelected(outSel), .timerInputSelected(inSel),
      .matchIrq(irq));
   timer_far_side src (.sys_clk(sys_clk), .high_internal_clock(hiClk),
      .sub_clock(subClk), .timer_clock_pin(extPin));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // pulse counter: a stretched pulse would count twice
   always @(posedge sys_clk) begin
      pinQ <= pin;
      if (irq.matchA === 1'b1) aCount++;
   end
   task automatic end_sim();
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // every bus and span wait runs through here, so a hang ends the run
   task automatic step();
      @(posedge sys_clk);
      guard++;
      if (guard > 20000) begin
         miscompares++;
         end_sim();
      end
   endtask : step
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      guard = 0;
      step();
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         step();
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rdr(input logic [4:0] a);
      guard = 0;
      step();
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         step();
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rdr
   // low byte first on writes, high byte first on reads
   task automatic wr_a(input logic [9:0] v);
      wr(ADDR_COMPARE_A_LOW, v[7:0]);
      wr(ADDR_COMPARE_A_HIGH, {6'h0, v[9:8]});
   endtask : wr_a
   task automatic rd_cnt();
      rdr(ADDR_COUNTER_HIGH);
      cnt[9:8] = rd[1:0];
      rdr(ADDR_COUNTER_LOW);
      cnt[7:0] = rd[7:0];
   endtask : rd_cnt
   task automatic restart(input logic [7:0] sec, pri);
      wr(ADDR_CONTROL_PRIMARY, 8'h00);
      wr(ADDR_CONTROL_SECONDARY, sec);
      wr(ADDR_CONTROL_PRIMARY, pri);
   endtask : restart
   // 0 match A, 1 match P, 2 pin rise, 3 pin fall
   function automatic logic ev(input int k);
      case (k)
         0: return irq.matchA;
         1: return irq.matchP;
         2: return pin & ~pinQ;
         default: return ~pin & pinQ;
      endcase
   endfunction : ev
   task automatic span(input int a, b);
      guard = 0;
      do step(); while (ev(a) !== 1'b1);
      n = 0;
      do begin
         step();
         n++;
      end while (ev(b) !== 1'b1);
   endtask : span
   logic [4:0] regs [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
   logic [7:0] secs [3] = '{8'h19, 8'h21, 8'h39};  // low, high, toggle
   logic       inits [3] = '{1'b1, 1'b0, 1'b1};
   logic       posts [3] = '{1'b0, 1'b1, 1'b1};   // after two matches
   int         divs [6] = '{4, 1, 32, 128, 16, 16}; // cycles per tick
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      wstrb = 4'hF;
      {awaddr, araddr, wdata} = 42'h0;
      rst_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (regs[i]) begin
         rdr(regs[i]);
         check("reset value", rd, 32'h0);
      end
      rdr(5'h1C);
      check("gap resp", resp, RESP_SLVERR);
      wr(ADDR_COUNTER_LOW, 8'h55);
      check("counter write", resp, RESP_SLVERR);
      wr(ADDR_PIN_SELECT, 8'h03);
      wstrb <= 4'h0;  // lane 0 off: the select bits must stay set
      wr(ADDR_PIN_SELECT, 8'h00);
      wstrb <= 4'hF;
      check("out select", outSel, 1'b1);
      check("in select", inSel, 1'b1);
      wr(ADDR_COMPARE_A_LOW, 8'h5A);
      rdr(ADDR_COMPARE_A_HIGH);
      rdr(ADDR_COMPARE_A_LOW);
      check("live low kept", rd, 32'h0);
      wr_a(10'h25A);
      rdr(ADDR_COMPARE_A_HIGH);
      check("A high", rd, 32'h2);
      rdr(ADDR_COMPARE_A_LOW);
      check("A low", rd, 32'h5A);
      wr_a(10'h020);
      for (int i = 0; i < 3; i++) begin
         restart(secs[i], 8'h18);
         step();  // pin follows the on edge two registers later
         step();
         check("initial pin", pin, inits[i]);
         span(0, 0);
         check("A period", n, 33);
         step();
         step();
         check("match pin", pin, posts[i]);
      end
      span(3, 2);
      check("toggle spacing", n, 33);
      for (int i = 0; i < 6; i++) begin
         restart(8'h01, {1'b0, i[2:0], 4'h8});
         span(0, 0);
         check("clock rate", n, 33 * divs[i]);
      end
      restart(8'h00, 8'h1B);
      span(1, 1);
      check("P period", n, 384);
      span(0, 0);
      check("A over P", n, 384);
      restart(8'h00, 8'h18);
      span(1, 1);
      check("overflow", n, 1024);
      restart(8'hA8, 8'h1B);
      span(2, 3);
      check("pwm duty", n, 32);
      span(2, 2);
      check("pwm period", n, 384);
      restart(8'hAC, 8'h1B);
      span(2, 3);
      check("pwm inverted", n, 352);
      wr_a(10'h003);
      restart(8'h01, 8'h68);
      src.pulses(2);
      rd_cnt();
      check("ext count", cnt, 10'h002);
      wr(ADDR_CONTROL_PRIMARY, 8'hE8);
      src.pulses(1);
      rd_cnt();
      check("paused", cnt, 10'h002);
      wr(ADDR_CONTROL_PRIMARY, 8'h60);
      src.pulses(1);
      rd_cnt();
      check("off kept", cnt, 10'h002);
      wr(ADDR_CONTROL_PRIMARY, 8'h68);
      rd_cnt();
      check("on clears", cnt, 10'h000);
      for (int i = 0; i < 2; i++) begin
         restart(8'h01, (i == 0) ? 8'h68 : 8'h78);
         n = aCount;
         src.pulses(3);
         src.level(1'b1);
         check("edge kind", aCount - n, 1 - i);
         src.level(1'b0);
         check("one pulse", aCount - n, 1);
      end
      end_sim();
   end
endmodule : compact_timer_module_bench
